// ===== hw/rbg_map.svh
// Timing counts, reset values and table constants of the bitstream generator
`ifndef RBG_MAP_SVH
`define RBG_MAP_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RBG_CLK_NS       100
`define RBG_BIT_HALF_NS  400
// Longest half period, so round down, never below one cycle
`define RBG_BIT_HALF_CYC (((`RBG_BIT_HALF_NS / `RBG_CLK_NS) < 1) ? 1 : \
                          (`RBG_BIT_HALF_NS / `RBG_CLK_NS))
// ----------------------------------------------------------------
// Reset values and tables
// ----------------------------------------------------------------
`define RBG_LEN_RST      6'h3f
`define RBG_PAT_RST      8'h00
`define RBG_MUX_LUT      16'h00ca
`define RBG_WORD_MSB     7
`define RBG_FIFO_DEPTH   32
`endif

// ===== hw/rbg_pkg.sv
// Types shared by the bitstream generator
package rbg_pkg;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RBG_S0 = 3'b000,
    RBG_S1 = 3'b001,
    RBG_S2 = 3'b010,
    RBG_S3 = 3'b011,
    RBG_S4 = 3'b100,
    RBG_S5 = 3'b101,
    RBG_S6 = 3'b110,
    RBG_S7 = 3'b111
  } rbg_state_t;
  // ----------------------------------------------------------------
  // Pattern write carried through the buffer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } rbg_pat_wr_t;
endpackage

// ===== hw/rbg_top.sv
// Repeating bitstream generator with its pattern write buffer
`include "rbg_map.svh"

// ----------------------------------------------------------------
// Pattern write buffer
// ----------------------------------------------------------------
module rbg_fifo #(
  parameter int W = 11,
  parameter int D = `RBG_FIFO_DEPTH
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  // Pointers wrap freely, so D must be a power of two
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW:0]   cntQ;
  logic [AW:0]   cntD;
  logic [AW-1:0] wrPtrQ;
  logic [AW-1:0] rdPtrQ;
  logic          push;
  logic          pop;
  assign push     = clkEn && inValid && inReady;
  assign pop      = clkEn && outValid && outReady;
  assign outValid = (cntQ != '0);
  assign outData  = mem[rdPtrQ];
  always_comb begin
    cntD = cntQ;
    if (push && !pop) begin
      cntD = cntQ + 1'b1;
    end else if (!push && pop) begin
      cntD = cntQ - 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtrQ] <= inData;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cntQ    <= '0;
      wrPtrQ  <= '0;
      rdPtrQ  <= '0;
      inReady <= 1'b1;
    end else if (clkEn) begin
      cntQ    <= cntD;
      wrPtrQ  <= wrPtrQ + AW'(push);
      rdPtrQ  <= rdPtrQ + AW'(pop);
      inReady <= (cntD != (AW + 1)'(D));
    end
  end
endmodule

// ----------------------------------------------------------------
// Generator top
// ----------------------------------------------------------------
// Functional notes
// - Stream of programmable length up to 64 bits repeats while enabled.
// - Terminal count sets repetition length; host may rewrite it.
// - Host writes per-state pattern bytes; later cycles use new values.
// - Clock line runs with data only when enabled; it paces the mux.
// - Stages high only for 0001, 0011, 0110, 0111; they form an 8:1 mux.
// - With enable low, data shows MSB of the current state's byte.
// - Sequencer changes state only on a step edge or a start edge, with its condition met.
// - Each step phase outlasts a state change; one change per phase.
// - Eight states in one ring act as a 3-bit counter supplying bytes.
// - Reset holds state 0; rising start input moves it to state 1.
// - Later state changes alternate with step clock rising then falling.
// - Guard stops adjacent transition conditions being true together.
module rbg_top #(
  parameter int BIT_HALF_CYC = `RBG_BIT_HALF_CYC,
  parameter int FIFO_DEPTH   = `RBG_FIFO_DEPTH
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clkEn,
  input  wire logic                 genEnable,
  input  wire logic                 sequenceStartInput,
  input  wire logic                 lenWrEn,
  input  wire logic [5:0]           lenWrData,
  input  wire logic                 patWrValid,
  input  wire rbg_pkg::rbg_pat_wr_t patWr,
  output logic                      patWrReady,
  output logic                      serData_q,
  output logic                      serClk_q,
  output logic                      stepClk_q,
  output rbg_pkg::rbg_state_t       stateQ
);
  logic                 enSync1_q;
  logic                 enSync2_q;
  logic                 startSync1_q;
  logic                 startSync2_q;
  logic                 startPrev_q;
  logic                 runQ;
  logic [7:0]           halfCntQ;
  logic [2:0]           bitSelQ;
  logic [5:0]           lenCntQ;
  logic [5:0]           lenTermQ;
  logic [7:0]           patMem_q [8];
  logic [7:0]           curWord;
  logic [15:1]          tree;
  logic                 muxBit;
  logic                 genOn;
  logic                 halfDone;
  logic                 bitAdv;
  logic                 lenEnd;
  logic                 stepEdge;
  logic                 startGo;
  logic                 popValid;
  logic                 popReady;
  rbg_pkg::rbg_pat_wr_t popWr;
  rbg_pkg::rbg_state_t  ringNext;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enSync1_q    <= 1'b0;
      enSync2_q    <= 1'b0;
      startSync1_q <= 1'b0;
      startSync2_q <= 1'b0;
      startPrev_q  <= 1'b0;
    end else if (clkEn) begin
      enSync1_q    <= genEnable;
      enSync2_q    <= enSync1_q;
      startSync1_q <= sequenceStartInput;
      startSync2_q <= startSync1_q;
      startPrev_q  <= startSync2_q;
    end
  end
  // Start can only act from idle, steps only while running
  assign startGo  = clkEn && startSync2_q && !startPrev_q
                    && !runQ;
  assign genOn    = enSync2_q && runQ;
  assign halfDone = (halfCntQ == 8'(BIT_HALF_CYC - 1));
  assign bitAdv   = clkEn && genOn && halfDone && serClk_q;
  assign lenEnd   = (lenCntQ == lenTermQ);
  assign stepEdge = bitAdv && ((bitSelQ == 3'h7) || lenEnd);
  // ----------------------------------------------------------------
  // Bit clock generator
  // ----------------------------------------------------------------
  // Data moves one cycle after the falling edge so the receiver samples mid-bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfCntQ <= 8'h00;
      serClk_q <= 1'b0;
    end else if (clkEn) begin
      if (!genOn) begin
        halfCntQ <= 8'h00;
        serClk_q <= 1'b0;
      end else if (halfDone) begin
        halfCntQ <= 8'h00;
        serClk_q <= !serClk_q;
      end else begin
        halfCntQ <= halfCntQ + 8'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // Bit and length counters
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitSelQ <= 3'h0;
      lenCntQ <= 6'h00;
    end else if (bitAdv) begin
      if (lenEnd) begin
        bitSelQ <= 3'h0;
        lenCntQ <= 6'h00;
      end else begin
        bitSelQ <= bitSelQ + 3'h1;
        lenCntQ <= lenCntQ + 6'h01;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lenTermQ <= `RBG_LEN_RST;
    end else if (clkEn && lenWrEn) begin
      lenTermQ <= lenWrData;
    end
  end

  // ----------------------------------------------------------------
  // Step clock and sequencer ring
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stepClk_q <= 1'b0;
    end else if (stepEdge) begin
      stepClk_q <= !stepClk_q;
    end
  end
  always_comb begin
    unique case (stateQ)
      rbg_pkg::RBG_S0: ringNext = rbg_pkg::RBG_S1;
      rbg_pkg::RBG_S1: ringNext = rbg_pkg::RBG_S2;
      rbg_pkg::RBG_S2: ringNext = rbg_pkg::RBG_S3;
      rbg_pkg::RBG_S3: ringNext = rbg_pkg::RBG_S4;
      rbg_pkg::RBG_S4: ringNext = rbg_pkg::RBG_S5;
      rbg_pkg::RBG_S5: ringNext = rbg_pkg::RBG_S6;
      rbg_pkg::RBG_S6: ringNext = rbg_pkg::RBG_S7;
      rbg_pkg::RBG_S7: ringNext = rbg_pkg::RBG_S0;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= rbg_pkg::RBG_S0;
    end else if (startGo) begin
      stateQ <= rbg_pkg::RBG_S1;
    end else if (stepEdge) begin
      stateQ <= lenEnd ? rbg_pkg::RBG_S1 : ringNext;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      runQ <= 1'b0;
    end else if (startGo) begin
      runQ <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pattern store fed through the write buffer
  // ----------------------------------------------------------------
  // Holding a write for the state on air avoids a torn byte
  assign popReady = !(genOn && (popWr.addr == stateQ));
  rbg_fifo #(
    .W ($bits(rbg_pkg::rbg_pat_wr_t)),
    .D (FIFO_DEPTH)
  ) rbg_fifo_inst (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (patWrValid),
    .inData   (patWr),
    .inReady  (patWrReady),
    .outValid (popValid),
    .outData  (popWr),
    .outReady (popReady)
  );
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        patMem_q[i] <= `RBG_PAT_RST;
      end
    end else if (clkEn && popValid && popReady) begin
      patMem_q[popWr.addr] <= popWr.data;
    end
  end

  // ----------------------------------------------------------------
  // Table multiplexer tree and data output
  // ----------------------------------------------------------------
  function automatic logic lut4(input logic [3:0] idx);
    logic [15:0] tbl;
    tbl  = `RBG_MUX_LUT;
    lut4 = tbl[idx];
  endfunction
  assign curWord = patMem_q[stateQ];
  // Heap order: leaves 8..15 hold the byte MSB first, node 1 is the root
  for (genvar g = 1; g < 16; g++) begin : g_tree
    if (g >= 8) begin : g_leaf
      assign tree[g] = curWord[15 - g];
    end else begin : g_node
      localparam int LV = (g >= 4) ? 0 : ((g >= 2) ? 1 : 2);
      assign tree[g] = lut4({1'b0, bitSelQ[LV], tree[2*g+1], tree[2*g]});
    end
  end
  assign muxBit = tree[1];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serData_q <= 1'b0;
    end else if (clkEn) begin
      serData_q <= genOn ? muxBit : curWord[`RBG_WORD_MSB];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seqWrapBit;
    bitAdv && lenEnd;
  endsequence
  sequence seqBackToStart;
    (lenCntQ == 6'h00) && (bitSelQ == 3'h0) && (stateQ == rbg_pkg::RBG_S1);
  endsequence

  chk_len_wrap: assert property (seqWrapBit |=> seqBackToStart)
    else $error("stream did not wrap at terminal count");
  chk_len_rewrite: assert property (clkEn && lenWrEn |=>
      lenTermQ == $past(lenWrData))
    else $error("length count not taken");
  chk_pat_write: assert property (clkEn && popValid && popReady |=>
      patMem_q[$past(popWr.addr)] == $past(popWr.data))
    else $error("pattern byte not stored");
  chk_clk_idle: assert property (clkEn && !genOn |=> !serClk_q)
    else $error("clock line ran while disabled");
  chk_mux_bit: assert property (muxBit == curWord[~bitSelQ])
    else $error("multiplexer picked wrong bit");
  chk_idle_msb: assert property (clkEn && !genOn |=>
      serData_q == $past(curWord[7]))
    else $error("idle data not the byte MSB");
  chk_state_cause: assert property ($changed(stateQ) |->
      $past(stepEdge) || $past(startGo))
    else $error("state moved without a step edge");
  chk_phase_width: assert property (stepEdge |=> !stepEdge [*3])
    else $error("two state changes in one phase");
  chk_ring_step: assert property (stepEdge && !lenEnd |=>
      stateQ == $past(ringNext))
    else $error("ring order broken");
  chk_hold_zero: assert property (!runQ && !startGo |=>
      stateQ == rbg_pkg::RBG_S0)
    else $error("left state 0 without start");
  chk_start_go: assert property (startGo |=>
      runQ && stateQ == rbg_pkg::RBG_S1)
    else $error("start did not reach state 1");
  chk_step_alt: assert property ($changed(stateQ) && $past(runQ) |->
      $changed(stepClk_q))
    else $error("state change off the step clock");
  chk_guard_excl: assert property (!(startGo && stepEdge))
    else $error("two transition conditions at once");
  chk_data_reg: assert property (clkEn && genOn |=>
      serData_q == $past(muxBit))
    else $error("data line not from multiplexer");
endmodule

// ===== dv/rbg_rx_model.sv
// Serial receiver model that samples the generated stream
module rbg_rx_model (
  input wire logic serClk,
  input wire logic serData
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  logic rxBits [$];
  // Only rising edges count, so a stopped clock adds no bits
  always @(posedge serClk) begin
    rxBits.push_back(serData);
  end
endmodule

// ===== dv/tb_repeating_bitstream_generator.sv
// Self-checking bench of the repeating bitstream generator
module tb_repeating_bitstream_generator;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                 ref_clk;
  logic                 rst_n;
  logic                 clkEn;
  logic                 genEnable;
  logic                 sequenceStartInput;
  logic                 lenWrEn;
  logic [5:0]           lenWrData;
  logic                 patWrValid;
  rbg_pkg::rbg_pat_wr_t patWr;
  logic                 patWrReady;
  logic                 serData_q;
  logic                 serClk_q;
  logic                 stepClk_q;
  rbg_pkg::rbg_state_t  stateQ;
  logic [7:0]           pat [8];
  int                   errors;
  int                   total_checks;

  rbg_top #(.BIT_HALF_CYC(4), .FIFO_DEPTH(32)) rbg_top_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .genEnable(genEnable), .sequenceStartInput(sequenceStartInput),
    .lenWrEn(lenWrEn), .lenWrData(lenWrData), .patWrValid(patWrValid),
    .patWr(patWr), .patWrReady(patWrReady), .serData_q(serData_q),
    .serClk_q(serClk_q), .stepClk_q(stepClk_q), .stateQ(stateQ));
  rbg_rx_model rbg_rx_model_inst (.serClk(serClk_q), .serData(serData_q));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_up(input string what);
    errors++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    close_out();
  endtask
  // Bit j of one repetition; a repetition starts at state 1, bit 7
  function automatic logic exp_bit(input int j);
    return pat[(j / 8 + 1) % 8][7 - j % 8];
  endfunction
  // Caller lowers valid, so back-to-back writes never glitch it
  task automatic wr_pat(input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    patWrValid = 1'b1;
    patWr.addr = a;
    patWr.data = d;
    // Ready is judged off the edge, where it has settled
    while (patWrReady !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    if (n >= 300) give_up("pattern write");
    step(1);
    pat[a] = d;
  endtask
  task automatic wr_len(input logic [5:0] d);
    lenWrEn = 1'b1;
    lenWrData = d;
    step(1);
    lenWrEn = 1'b0;
  endtask
  task automatic wait_change;
    rbg_pkg::rbg_state_t s;
    int n;
    s = stateQ;
    n = 0;
    while (stateQ === s && n < 300) begin
      step(1);
      n++;
    end
    if (n >= 300) give_up("state change");
  endtask
  // Any rotation passes: the capture may start mid-repetition
  task automatic chk_stream(input int len, input int nb);
    int n;
    bit ok;
    bit hit;
    n = 0;
    hit = 1'b0;
    rbg_rx_model_inst.rxBits.delete();
    while (rbg_rx_model_inst.rxBits.size() < nb && n < nb * 10 + 100) begin
      step(1);
      n++;
    end
    if (rbg_rx_model_inst.rxBits.size() < nb) give_up("stream capture");
    for (int k = 0; k < len && !hit; k++) begin
      ok = 1'b1;
      for (int i = 0; i < nb; i++)
        if (rbg_rx_model_inst.rxBits[i] !== exp_bit((i + k) % len)) ok = 0;
      hit = ok;
    end
    chk("stream match", 8'h01, {7'h0, hit});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("reset state", 8'h00, {5'h0, stateQ});
    chk("reset bit clock", 8'h00, {7'h0, serClk_q});
    chk("reset data", 8'h00, {7'h0, serData_q});
    chk("reset ready", 8'h01, {7'h0, patWrReady});
    $display("test reset done");
  endtask
  task automatic t_load;
    logic [7:0] v [8];
    v = '{8'h9c, 8'ha5, 8'h3c, 8'hf0, 8'h0f, 8'h66, 8'hc3, 8'h18};
    for (int i = 0; i < 8; i++) wr_pat(i[2:0], v[i]);
    patWrValid = 1'b0;
    wr_len(6'h13);
    step(8);
    chk("idle msb", {7'h0, pat[0][7]}, {7'h0, serData_q});
    chk("idle state", 8'h00, {5'h0, stateQ});
    $display("test load done");
  endtask
  task automatic t_start;
    logic s;
    sequenceStartInput = 1'b1;
    step(6);
    chk("start state", 8'h01, {5'h0, stateQ});
    genEnable = 1'b1;
    chk_stream(20, 60);
    wait_change();
    s = stepClk_q;
    wait_change();
    chk("step clock phase", {7'h0, ~s}, {7'h0, stepClk_q});
    $display("test start done");
  endtask
  task automatic t_pause;
    rbg_pkg::rbg_state_t s;
    logic c;
    logic m;
    genEnable = 1'b0;
    step(12);
    s = stateQ;
    repeat (16) begin
      step(1);
      m = pat[stateQ][7];
      chk("paused clock", 8'h00, {7'h0, serClk_q});
      chk("paused data", {7'h0, m}, {7'h0, serData_q});
      chk("paused state", {5'h0, s}, {5'h0, stateQ});
    end
    genEnable = 1'b1;
    step(20);
    clkEn = 1'b0;
    s = stateQ;
    c = serClk_q;
    step(80);
    chk("frozen state", {5'h0, s}, {5'h0, stateQ});
    chk("frozen clock", {7'h0, c}, {7'h0, serClk_q});
    clkEn = 1'b1;
    $display("test pause done");
  endtask
  task automatic t_length;
    wr_len(6'h0b);
    step(700);
    chk_stream(12, 40);
    $display("test length done");
  endtask
  // Writes aimed at the state on air stay queued until it moves on
  task automatic t_fill;
    logic [2:0] a;
    int acc;
    int n;
    acc = 0;
    n = 0;
    wr_len(6'h3f);
    step(700);
    wait_change();
    a = stateQ;
    patWrValid = 1'b1;
    patWr.addr = a;
    patWr.data = 8'h5a;
    // Ready seen off the edge decides whether the next edge takes it
    repeat (40) begin
      if (patWrReady === 1'b1) acc++;
      step(1);
    end
    patWrValid = 1'b0;
    chk("full ready", 8'h00, {7'h0, patWrReady});
    chk("accepted words", 8'h20, acc[7:0]);
    while (patWrReady !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    if (n >= 300) give_up("buffer drain");
    pat[a] = 8'h5a;
    step(600);
    chk_stream(64, 140);
    $display("test fill done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    genEnable = 1'b0;
    sequenceStartInput = 1'b0;
    lenWrEn = 1'b0;
    lenWrData = 6'h00;
    patWrValid = 1'b0;
    patWr = '0;
    for (int i = 0; i < 8; i++) pat[i] = 8'h00;
    step(20);
    rst_n = 1'b1;
    t_reset();
    t_load();
    t_start();
    t_pause();
    t_length();
    t_fill();
    close_out();
  end
endmodule
